// ---- logic/cmx_pkg.sv ----
package cmx_pkg;

    // apb register byte offsets
    localparam logic [7:0] ADDR_INSTR   = 8'h00; // write issues an instruction
    localparam logic [7:0] ADDR_STATUS  = 8'h04; // busy and flags, read only
    localparam logic [7:0] ADDR_FLAGS   = 8'h08; // zero and carry flags, read/write
    localparam logic [7:0] ADDR_RF_ADDR = 8'h0c; // register file pointer
    localparam logic [7:0] ADDR_RF_DATA = 8'h10; // register file word at pointer

    // status and flag bit positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_Z    = 1;
    localparam int STAT_C    = 2;
    localparam int FLAG_Z    = 0;
    localparam int FLAG_C    = 1;

    // opcodes
    localparam logic [5:0] OP_HUB           = 6'h03;
    localparam logic [5:0] OP_UNS_UPPER     = 6'h13;
    localparam logic [5:0] OP_SGN_UPPER     = 6'h11;
    localparam logic [5:0] OP_UNS_LOWER     = 6'h12;
    localparam logic [5:0] OP_SGN_LOWER     = 6'h10;
    localparam logic [5:0] OP_COPY          = 6'h28;
    localparam logic [5:0] OP_DEST_INSERT   = 6'h15;
    localparam logic [5:0] OP_INSTR_INSERT  = 6'h16;
    localparam logic [5:0] OP_SRC_INSERT    = 6'h14;
    localparam logic [5:0] OP_CARRY_MERGE   = 6'h1c;
    localparam logic [2:0] HUB_LOCK_SET     = 3'h6;

    // field positions inside a 32-bit word, register file depth, lock id width
    localparam int FLD_W      = 9;
    localparam int DFLD_LO    = 9;
    localparam int IFLD_LO    = 23;
    localparam int RF_DEPTH   = 512;
    localparam int LOCK_ID_W  = 3;

    // timing: clock period in ns, op lengths in system clocks
    localparam int          CLK_PERIOD_NS = 8;
    localparam logic [4:0]  ALU_CLKS      = 5'h04;
    localparam logic [4:0]  HUB_MIN_CLKS  = 5'h07;
    localparam logic [4:0]  HUB_MAX_CLKS  = 5'h16;

    // instruction word layout
    typedef struct packed {
        logic [5:0] opc;   // operation
        logic       zeff;  // zero_flag_write_effect
        logic       ceff;  // carry_flag_write_effect
        logic       rwr;   // result write; clear means result_suppress_effect
        logic       imm;   // source field is a literal
        logic [3:0] cond;  // condition, not evaluated here
        logic [8:0] dst;   // destination register
        logic [8:0] src;   // source register or literal
    } cmx_instr_t;

    // request to the shared hub
    typedef struct packed {
        logic       req;
        logic [2:0] op;
        logic [2:0] lock_id;
    } cmx_hub_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ALU  = 3'b010,
        ST_HUB  = 3'b100
    } cmx_state_t;

endpackage : cmx_pkg

// ---- logic/cmx_exec.sv ----
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// RQ1: lock set forces lock; prior state to carry
// RQ2: lock id 0..7 from destination register
// RQ3: hub op stalls 7 to 22 clocks
// RQ4: unsigned upper clamp keeps the smaller
// RQ5: signed upper clamp keeps the smaller
// RQ6: unsigned lower clamp keeps the greater
// RQ7: signed lower clamp keeps the greater
// RQ8: unsigned clamps: zero equal, carry unsigned less
// RQ9: signed clamps: zero equal, carry signed less
// RQ10: copy stores source; zero flags zero source
// RQ11: copy carry takes source msb
// RQ12: insert source low nine into bits 17..9
// RQ13: insert source low nine into bits 31..23
// RQ14: insert source low nine into bits 8..0
// RQ15: mask merge sets masked bits to carry
// RQ16: merge flags: zero result, odd parity carry
// RQ17: result written unless suppression requested
// RQ18: source is register or nine-bit literal
// RQ19: non-hub operations take four clocks
// RQ20: flag kept when its write effect clear
module cmx_exec (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // shared hub
    output cmx_pkg::cmx_hub_req_t     hub_req,
    input  wire logic                 hub_ack,
    input  wire logic                 hub_prior
);

    logic [31:0]            rf_q [cmx_pkg::RF_DEPTH]; // operand register file
    cmx_pkg::cmx_instr_t    ir_q;       // instruction in flight
    cmx_pkg::cmx_state_t    st_q;       // sequencer state
    logic [4:0]             cnt_q;      // clocks spent in current op
    logic                   z_q;        // zero flag
    logic                   c_q;        // carry flag
    logic [8:0]             rfa_q;      // register file pointer
    logic                   ack_seen_q; // hub answered already
    logic                   prior_q;    // prior lock state from hub
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    cmx_pkg::cmx_hub_req_t  hub_q;

    // operands and results
    logic [31:0] d_op;
    logic [31:0] s_op;
    logic [31:0] res;
    logic        zv;
    logic        cv;
    logic        known;
    logic        ult;
    logic        slt;
    logic        eq;

    // bus decode
    logic        setup;
    logic        acc;
    logic        busy;
    logic        mapped;
    logic        refuse;
    logic        fin_alu;
    logic        fin_hub;
    logic        start;
    logic        is_lock_set;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign hub_req = hub_q;

    // address decode, used for both mapping and refusal
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
        is_addr = (a == ref_a);
    endfunction : is_addr

    assign busy   = (st_q != cmx_pkg::ST_IDLE);
    assign setup  = psel & ~penable;
    assign acc    = psel & penable & pready_q & ~pslverr_q;
    assign mapped = is_addr(paddr, cmx_pkg::ADDR_INSTR)   |
                    is_addr(paddr, cmx_pkg::ADDR_STATUS)  |
                    is_addr(paddr, cmx_pkg::ADDR_FLAGS)   |
                    is_addr(paddr, cmx_pkg::ADDR_RF_ADDR) |
                    is_addr(paddr, cmx_pkg::ADDR_RF_DATA);
    // state-changing writes other than to the register file pointer are refused while an instruction runs,
    // so software can never race the writeback or the flag update
    assign refuse = ~mapped | (pwrite & busy & ~is_addr(paddr, cmx_pkg::ADDR_RF_ADDR));
    assign start  = acc & pwrite & is_addr(paddr, cmx_pkg::ADDR_INSTR);

    // operand fetch
    always_comb begin
        d_op = rf_q[ir_q.dst];
        // literal is zero-extended nine-bit field
        if (ir_q.imm) begin // [RQ18]
            s_op = {{(32-cmx_pkg::FLD_W){1'b0}}, ir_q.src};
        end else begin
            s_op = rf_q[ir_q.src];
        end
    end

    assign ult = d_op < s_op;
    assign slt = $signed(d_op) < $signed(s_op);
    assign eq  = d_op == s_op;
    assign is_lock_set = (ir_q.opc == cmx_pkg::OP_HUB) &&
                         (s_op[2:0] == cmx_pkg::HUB_LOCK_SET);

    // result and flag values per operation
    always_comb begin
        res   = d_op;
        zv    = z_q;
        cv    = c_q;
        known = 1'b1;
        unique case (ir_q.opc)
            cmx_pkg::OP_UNS_UPPER: begin
                res = ult ? d_op : s_op; // [RQ4]
                zv  = eq;                // [RQ8]
                cv  = ult;               // [RQ8]
            end
            cmx_pkg::OP_SGN_UPPER: begin
                res = slt ? d_op : s_op; // [RQ5]
                zv  = eq;                // [RQ9]
                cv  = slt;               // [RQ9]
            end
            cmx_pkg::OP_UNS_LOWER: begin
                res = ult ? s_op : d_op; // [RQ6]
                zv  = eq;                // [RQ8]
                cv  = ult;               // [RQ8]
            end
            cmx_pkg::OP_SGN_LOWER: begin
                res = slt ? s_op : d_op; // [RQ7]
                zv  = eq;                // [RQ9]
                cv  = slt;               // [RQ9]
            end
            cmx_pkg::OP_COPY: begin
                res = s_op;              // [RQ10]
                zv  = (s_op == 32'h0);   // [RQ10]
                cv  = s_op[31];          // [RQ11]
            end
            cmx_pkg::OP_DEST_INSERT: begin
                res = {d_op[31:cmx_pkg::DFLD_LO+cmx_pkg::FLD_W],
                       s_op[cmx_pkg::FLD_W-1:0],
                       d_op[cmx_pkg::DFLD_LO-1:0]}; // [RQ12]
                zv  = (s_op == 32'h0);                // [RQ12]
            end
            cmx_pkg::OP_INSTR_INSERT: begin
                res = {s_op[cmx_pkg::FLD_W-1:0], d_op[cmx_pkg::IFLD_LO-1:0]}; // [RQ13]
                zv  = (s_op == 32'h0);                                        // [RQ13]
            end
            cmx_pkg::OP_SRC_INSERT: begin
                res = {d_op[31:cmx_pkg::FLD_W], s_op[cmx_pkg::FLD_W-1:0]}; // [RQ14]
                zv  = (s_op == 32'h0);                                    // [RQ14]
            end
            cmx_pkg::OP_CARRY_MERGE: begin
                res = (d_op & ~s_op) | ({32{c_q}} & s_op); // [RQ15]
                zv  = (res == 32'h0);                      // [RQ16]
                cv  = ^res;                                // [RQ16]
            end
            default: begin
                // opcodes outside this block retire as no-ops, except a hub lock set, which stalls on the hub
                known = 1'b0;
            end
        endcase
    end

    assign fin_alu = (st_q == cmx_pkg::ST_ALU) && (cnt_q == cmx_pkg::ALU_CLKS - 5'h01);
    // hub op ends once answered and at least the least stall has passed
    assign fin_hub = (st_q == cmx_pkg::ST_HUB) && (ack_seen_q | hub_ack) &&
                     (cnt_q >= cmx_pkg::HUB_MIN_CLKS - 5'h01); // [RQ3]

    // apb answer: ready in the first access cycle, data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= refuse;
                prdata_q  <= 32'h0;
                if (!pwrite) begin
                    unique case (1'b1)
                        is_addr(paddr, cmx_pkg::ADDR_INSTR):
                            prdata_q <= ir_q;
                        is_addr(paddr, cmx_pkg::ADDR_STATUS): begin
                            prdata_q[cmx_pkg::STAT_BUSY] <= busy;
                            prdata_q[cmx_pkg::STAT_Z]    <= z_q;
                            prdata_q[cmx_pkg::STAT_C]    <= c_q;
                        end
                        is_addr(paddr, cmx_pkg::ADDR_FLAGS): begin
                            prdata_q[cmx_pkg::FLAG_Z] <= z_q;
                            prdata_q[cmx_pkg::FLAG_C] <= c_q;
                        end
                        is_addr(paddr, cmx_pkg::ADDR_RF_ADDR):
                            prdata_q <= {23'h0, rfa_q};
                        is_addr(paddr, cmx_pkg::ADDR_RF_DATA):
                            prdata_q <= rf_q[rfa_q];
                        default: prdata_q <= 32'h0; // unmapped reads zero
                    endcase
                end
            end else if (!psel) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // register file pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rfa_q <= 9'h0;
        end else if (acc && pwrite && is_addr(paddr, cmx_pkg::ADDR_RF_ADDR)) begin
            rfa_q <= pwdata[8:0];
        end
    end

    // register file: software window when idle, writeback at op end
    // array has no reset; a large memory would not take one anyway
    always_ff @(posedge pclk) begin
        if (acc && pwrite && is_addr(paddr, cmx_pkg::ADDR_RF_DATA)) begin
            rf_q[rfa_q] <= pwdata;
        end else if (fin_alu && known && ir_q.rwr) begin // [RQ17]
            rf_q[ir_q.dst] <= res;
        end
    end

    // instruction register, loaded only on an accepted issue
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_q <= '0;
        end else if (start) begin
            ir_q <= pwdata;
        end
    end

    // sequencer: four-clock alu path or hub stall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= cmx_pkg::ST_IDLE;
            cnt_q <= 5'h0;
        end else begin
            unique case (st_q)
                cmx_pkg::ST_IDLE: begin
                    cnt_q <= 5'h0;
                    if (start) begin
                        st_q <= cmx_pkg::ST_ALU;
                    end
                end
                cmx_pkg::ST_ALU: begin
                    // first alu clock decides whether the hub is needed
                    if (cnt_q == 5'h0 && is_lock_set) begin
                        st_q <= cmx_pkg::ST_HUB;
                    end else if (fin_alu) begin // [RQ19]
                        st_q <= cmx_pkg::ST_IDLE;
                    end
                    cnt_q <= cnt_q + 5'h01;
                end
                cmx_pkg::ST_HUB: begin
                    if (fin_hub) begin
                        st_q <= cmx_pkg::ST_IDLE;
                    end
                    // saturate: the hub owns the upper bound
                    if (cnt_q != cmx_pkg::HUB_MAX_CLKS) begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                default: begin
                    st_q <= cmx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // hub request: raised on entry, held until the hub answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hub_q      <= '0;
            ack_seen_q <= 1'b0;
            prior_q    <= 1'b0;
        end else begin
            if (st_q == cmx_pkg::ST_ALU && cnt_q == 5'h0 && is_lock_set) begin
                hub_q.req     <= 1'b1;                              // [RQ1]
                hub_q.op      <= cmx_pkg::HUB_LOCK_SET;             // [RQ1]
                hub_q.lock_id <= d_op[cmx_pkg::LOCK_ID_W-1:0];      // [RQ2]
                ack_seen_q    <= 1'b0;
            end else if (st_q == cmx_pkg::ST_HUB && hub_ack) begin
                hub_q.req  <= 1'b0; // [RQ3]
                ack_seen_q <= 1'b1;
                prior_q    <= hub_prior;
            end
        end
    end

    // flags: op results, lock prior state, or software when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            z_q <= 1'b0;
            c_q <= 1'b0;
        end else if (fin_alu && known) begin
            if (ir_q.zeff) begin // [RQ20]
                z_q <= zv;
            end
            if (ir_q.ceff) begin // [RQ20]
                c_q <= cv;
            end
        end else if (fin_hub) begin
            if (ir_q.ceff) begin // [RQ1]
                c_q <= hub_ack ? hub_prior : prior_q;
            end
        end else if (acc && pwrite && is_addr(paddr, cmx_pkg::ADDR_FLAGS)) begin
            z_q <= pwdata[cmx_pkg::FLAG_Z];
            c_q <= pwdata[cmx_pkg::FLAG_C];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_alu_four_clocks: assert property ( // [RQ19]
        $rose(st_q == cmx_pkg::ST_ALU) && !is_lock_set |->
        (st_q == cmx_pkg::ST_ALU)[*4] ##1 (st_q == cmx_pkg::ST_IDLE))
        else $error("alu op not four clocks");
    chk_hub_min_stall: assert property ( // [RQ3]
        $rose(st_q == cmx_pkg::ST_HUB) |-> (st_q == cmx_pkg::ST_HUB)[*6])
        else $error("hub op ended too early");
    chk_lock_id_src: assert property ( // [RQ2]
        hub_q.req |-> hub_q.lock_id == d_op[2:0] && hub_q.op == cmx_pkg::HUB_LOCK_SET)
        else $error("lock id not from destination");
    chk_hub_no_write: assert property ( // [RQ1]
        fin_hub |=> rf_q[ir_q.dst] == $past(d_op))
        else $error("hub op wrote a register");
    chk_uns_upper: assert property ( // [RQ4]
        fin_alu && ir_q.opc == cmx_pkg::OP_UNS_UPPER |->
        res <= d_op && res <= s_op && (res == d_op || res == s_op))
        else $error("unsigned upper clamp wrong");
    chk_sgn_upper: assert property ( // [RQ5]
        fin_alu && ir_q.opc == cmx_pkg::OP_SGN_UPPER |->
        !($signed(res) > $signed(s_op)) && (res == d_op || res == s_op))
        else $error("signed upper clamp wrong");
    chk_uns_lower: assert property ( // [RQ6]
        fin_alu && ir_q.opc == cmx_pkg::OP_UNS_LOWER |-> res >= d_op && res >= s_op)
        else $error("unsigned lower clamp wrong");
    chk_sgn_lower: assert property ( // [RQ7]
        fin_alu && ir_q.opc == cmx_pkg::OP_SGN_LOWER |->
        !($signed(res) < $signed(d_op)) && (res == d_op || res == s_op))
        else $error("signed lower clamp wrong");
    chk_merge_mask: assert property ( // [RQ15]
        fin_alu && ir_q.opc == cmx_pkg::OP_CARRY_MERGE |->
        ((res ^ d_op) & ~s_op) == 32'h0 && (res & s_op) == ({32{c_q}} & s_op))
        else $error("mask merge touched wrong bits");
    chk_merge_parity: assert property ( // [RQ16]
        fin_alu && ir_q.opc == cmx_pkg::OP_CARRY_MERGE && ir_q.ceff |=>
        c_q == ^$past(res))
        else $error("merge carry not parity");
    chk_result_write: assert property ( // [RQ17]
        fin_alu && known |=>
        rf_q[ir_q.dst] == ($past(ir_q.rwr) ? $past(res) : $past(d_op)))
        else $error("writeback or suppression wrong");
    chk_flag_hold: assert property ( // [RQ20]
        fin_alu && !ir_q.zeff && !ir_q.ceff |=> $stable(z_q) && $stable(c_q))
        else $error("flag changed without effect");
    chk_literal_src: assert property ( // [RQ18]
        ir_q.imm |-> s_op == {23'h0, ir_q.src})
        else $error("literal source wrong");

    cov_alu_op:   cover property (fin_alu && known && ir_q.rwr);
    cov_suppress: cover property (fin_alu && known && !ir_q.rwr);
    cov_hub_op:   cover property (fin_hub && ir_q.ceff);
    cov_refused:  cover property (setup && refuse);

endmodule : cmx_exec

// ---- tb/cmx_hub_model.sv ----
`timescale 1ns/1ps

// shared hub stand-in: eight lock bits, grant after a bench-chosen wait
module cmx_hub_model (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // core side
    input  wire cmx_pkg::cmx_hub_req_t hub_req,
    output logic                       hub_ack,
    output logic                       hub_prior,
    // bench control
    input  wire logic [4:0]            ack_wait
);
    logic [7:0] locks_q; // lock bits, all clear after reset
    logic [4:0] cnt_q;   // cycles the pending request has waited

    // prior toggles outside a grant, so a stale value never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locks_q   <= 8'h00;
            cnt_q     <= 5'h00;
            hub_ack   <= 1'b0;
            hub_prior <= 1'b0;
        end else begin
            hub_ack   <= 1'b0;
            hub_prior <= ~hub_prior;
            // skip the edge of our own grant: req is still high there
            if (hub_req.req && !hub_ack) begin
                if (cnt_q >= ack_wait) begin // access window reached
                    hub_ack   <= 1'b1;
                    hub_prior <= locks_q[hub_req.lock_id];
                    cnt_q     <= 5'h00;
                    if (hub_req.op == cmx_pkg::HUB_LOCK_SET) begin
                        locks_q[hub_req.lock_id] <= 1'b1;
                    end
                end else begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end
endmodule : cmx_hub_model

// ---- tb/test_cmx_exec.sv ----
`timescale 1ns/1ps

module test_cmx_exec;
    logic                  pclk    = 1'b0;
    logic                  presetn = 1'b0;
    logic                  psel    = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite  = 1'b0;
    logic [7:0]            paddr   = 8'h00;
    logic [31:0]           pwdata  = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    cmx_pkg::cmx_hub_req_t hub_req;
    logic                  hub_ack;
    logic                  hub_prior;
    logic [4:0]            hub_wait = 5'h00; // hub grant delay
    int                    bad_count = 0;
    int                    compares  = 0;
    time                   t_setup;          // time of last setup edge

    always #4 pclk = ~pclk;

    cmx_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hub_req(hub_req), .hub_ack(hub_ack),
        .hub_prior(hub_prior));

    cmx_hub_model i_hub (.pclk(pclk), .presetn(presetn), .hub_req(hub_req),
        .hub_ack(hub_ack), .hub_prior(hub_prior), .ack_wait(hub_wait));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    // one transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        t_setup = $time;
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        er = pslverr;
        if (n >= 40) chk_bit(1'b0, 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk_bit(e, ee);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk_bit(e, 1'b0);
    endtask : rd

    task automatic rf_put(input logic [8:0] a, input logic [31:0] v);
        wr(cmx_pkg::ADDR_RF_ADDR, {23'h0, a});
        wr(cmx_pkg::ADDR_RF_DATA, v);
    endtask : rf_put

    task automatic rf_get(input logic [8:0] a, output logic [31:0] v);
        wr(cmx_pkg::ADDR_RF_ADDR, {23'h0, a});
        rd(cmx_pkg::ADDR_RF_DATA, v);
    endtask : rf_get

    // zcri: zero effect, carry effect, result write, immediate
    function automatic logic [31:0] mk(logic [5:0] op, logic [3:0] zcri, logic [8:0] d,
                                       logic [8:0] s);
        return {op, zcri, 4'hf, d, s};
    endfunction : mk

    // flags given as {carry, zero}; dest is reg 0x20, source reg 0x21 or literal
    task automatic run_op(input logic [5:0] op, input logic [3:0] zcri,
                          input logic [31:0] dv, input logic [31:0] sv, input logic [1:0] fin,
                          input logic [31:0] er, input logic [1:0] ef);
        logic [31:0] r;
        rf_put(9'h020, dv);
        rf_put(9'h021, sv);
        wr(cmx_pkg::ADDR_FLAGS, {30'h0, fin});
        wr(cmx_pkg::ADDR_INSTR, mk(op, zcri, 9'h020, zcri[0] ? sv[8:0] : 9'h021));
        rd(cmx_pkg::ADDR_STATUS, r);
        chk_bit(r[0], 1'b1);
        rd(cmx_pkg::ADDR_STATUS, r);
        chk_word(r & 32'h7, {29'h0, ef, 1'b0});
        rf_get(9'h020, r);
        chk_word(r, er);
    endtask : run_op

    // lock set through the hub, carry effect on, dest reg 0x30 holds the id
    task automatic run_lock(input logic [31:0] idv, input logic [4:0] dly, input logic pr);
        logic [31:0] r;
        int          k;
        time         t0;
        rf_put(9'h030, idv);
        wr(cmx_pkg::ADDR_FLAGS, {30'h0, ~pr, 1'b0});
        hub_wait <= dly;
        wr(cmx_pkg::ADDR_INSTR, mk(cmx_pkg::OP_HUB, 4'b0101, 9'h030,
                                   {6'h0, cmx_pkg::HUB_LOCK_SET}));
        t0 = $time;
        wr(cmx_pkg::ADDR_FLAGS, 32'h0, 1'b1); // refused while busy
        k = 0;
        do begin
            rd(cmx_pkg::ADDR_STATUS, r);
            k++;
        end while (r[0] !== 1'b0 && k < 12);
        chk_bit((t_setup - t0) / 8 >= 8 && (t_setup - t0) / 8 <= 25, 1'b1);
        chk_word(r & 32'h7, {29'h0, pr, 2'b00});
        rf_get(9'h030, r);
        chk_word(r, idv);
    endtask : run_lock

    task automatic results;
        $display("mismatches %0d of %0d comparisons", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        #(8 * 20000);
        bad_count++;
        $display("CHECK FAILED t=%0t run hung", $time);
        results();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(cmx_pkg::ADDR_STATUS, r);
        chk_word(r, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk_bit(e, 1'b1);
        chk_word(r, 32'h0);
        $display("test reset and decode done");
        run_op(cmx_pkg::OP_UNS_UPPER, 4'b1110, 32'hffff0000, 32'h5,
               2'b11, 32'h5, 2'b00);
        run_op(cmx_pkg::OP_SGN_UPPER, 4'b1110, 32'hffff0000, 32'h5,
               2'b00, 32'hffff0000, 2'b10);
        run_op(cmx_pkg::OP_UNS_LOWER, 4'b1110, 32'h5, 32'hffff0000,
               2'b00, 32'hffff0000, 2'b10);
        run_op(cmx_pkg::OP_SGN_LOWER, 4'b1110, 32'h5, 32'hffff0000,
               2'b11, 32'h5, 2'b00);
        run_op(cmx_pkg::OP_SGN_LOWER, 4'b0010, 32'hffff0000, 32'h5,
               2'b11, 32'h5, 2'b11);
        run_op(cmx_pkg::OP_UNS_UPPER, 4'b1111, 32'h1ff, 32'hfffff1ff,
               2'b00, 32'h1ff, 2'b01);
        run_op(cmx_pkg::OP_COPY, 4'b1110, 32'h0, 32'h80000000,
               2'b01, 32'h80000000, 2'b10);
        run_op(cmx_pkg::OP_COPY, 4'b1100, 32'h11, 32'h0,
               2'b10, 32'h11, 2'b01);
        run_op(cmx_pkg::OP_DEST_INSERT, 4'b1010, 32'hffffffff, 32'h155,
               2'b10, 32'hfffeabff, 2'b10);
        run_op(cmx_pkg::OP_INSTR_INSERT, 4'b1010, 32'h0, 32'h1a5,
               2'b01, 32'hd2800000, 2'b00);
        run_op(cmx_pkg::OP_SRC_INSERT, 4'b1011, 32'hffffffff, 32'h200,
               2'b00, 32'hfffffe00, 2'b01);
        run_op(cmx_pkg::OP_CARRY_MERGE, 4'b1110, 32'h0, 32'h7,
               2'b10, 32'h7, 2'b10);
        run_op(cmx_pkg::OP_CARRY_MERGE, 4'b1110, 32'hf, 32'hf,
               2'b00, 32'h0, 2'b01);
        $display("test register operations done");
        run_lock(32'h5, 5'h00, 1'b0);
        run_lock(32'h5, 5'h11, 1'b1);
        run_lock(32'h2, 5'h03, 1'b0);
        $display("test lock set done");
        results();
    end
endmodule : test_cmx_exec
